// ==== hdl/cdpt_pkg.sv ====
// Constants and types for the channel delay and pulse timer
package cdpt_pkg;

  localparam int unsigned CH_NUM = 3;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned ADDR_W = 12;

  // Register byte addresses
  localparam logic [11:0] ADDR_OPCTL = 12'h000;
  localparam logic [11:0] ADDR_CLKCTL = 12'h004;
  localparam logic [11:0] ADDR_DIVCTL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_CH_BASE = 12'h010;
  localparam logic [11:0] ADDR_CH_STRIDE = 12'h010;
  localparam logic [11:0] CH_DELAY_OFS = 12'h000;
  localparam logic [11:0] CH_PON_OFS = 12'h004;
  localparam logic [11:0] CH_POFF_OFS = 12'h008;

  // Field positions
  localparam int unsigned OPCTL_MODE_LSB = 0;
  localparam int unsigned OPCTL_FBDIS_BIT = 5;
  localparam int unsigned CLK_SRC_LSB = 1;
  localparam int unsigned DIV_DLY_LSB = 0;
  localparam int unsigned DIV_PLS_LSB = 8;
  localparam int unsigned ST_OUT_LSB = 0;
  localparam int unsigned ST_EN_LSB = 4;
  localparam int unsigned ST_OFF_LSB = 12;
  localparam int unsigned ST_DIVLOW_BIT = 8;
  localparam int unsigned ST_EXT_BIT = 9;

  // Clock source codes
  localparam logic [1:0] CLK_SRC_INT = 2'h0;
  localparam logic [1:0] CLK_SRC_EXT = 2'h1;

  // Values after reset
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic RST_FBDIS = 1'b0;
  localparam logic [1:0] RST_CLK_SRC = 2'h0;
  localparam logic [3:0] RST_DIV = 4'h0;
  localparam logic [9:0] RST_COUNT = 10'h000;

  // Timing
  localparam int unsigned PCLK_PERIOD_NS = 20;
  localparam int unsigned INT_TICK_NS = 40;
  localparam int unsigned INT_TICK_CYC = INT_TICK_NS / PCLK_PERIOD_NS;
  localparam logic [3:0] DIV_MAX_LOG2 = 4'h7;
  localparam logic [3:0] MPG_MIN_DIV_LOG2 = 4'h3;

  typedef enum logic [1:0] {
    CDPT_MODE_OPEN = 2'b00,
    CDPT_MODE_CPC = 2'b01,
    CDPT_MODE_IPC = 2'b10
  } cdpt_mode_t;

  typedef enum logic [2:0] {
    CDPT_ST_IDLE = 3'b000,
    CDPT_ST_DELAY = 3'b001,
    CDPT_ST_PON = 3'b010,
    CDPT_ST_POFF = 3'b011,
    CDPT_ST_STEADY = 3'b100
  } cdpt_state_t;

endpackage : cdpt_pkg

// ==== hdl/cdpt_ch_if.sv ====
// Link between the control logic and one channel timer
`timescale 1ns/10ps
`default_nettype none
interface cdpt_ch_if;
  logic en;
  logic tick_delay;
  logic tick_pulse;
  logic [cdpt_pkg::CNT_W-1:0] delay_cnt;
  logic [cdpt_pkg::CNT_W-1:0] pulse_on_cnt;
  logic [cdpt_pkg::CNT_W-1:0] pulse_off_cnt;
  logic out_on;
  logic off_phase;

  modport ctl (
    output en, tick_delay, tick_pulse, delay_cnt, pulse_on_cnt,
    output pulse_off_cnt,
    input out_on, off_phase
  );
  modport tmr (
    input en, tick_delay, tick_pulse, delay_cnt, pulse_on_cnt,
    input pulse_off_cnt,
    output out_on, off_phase
  );
endinterface : cdpt_ch_if
`default_nettype wire

// ==== hdl/cdpt_ch_timer.sv ====
// One channel: turn-on delay and on/off pulse train
`timescale 1ns/10ps
`default_nettype none
module cdpt_ch_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  cdpt_ch_if.tmr ch
);

  cdpt_pkg::cdpt_state_t state_r;
  cdpt_pkg::cdpt_state_t state_nxt;
  logic en_prev_r;
  logic rise;
  logic [cdpt_pkg::CNT_W-1:0] cnt_r;
  logic [cdpt_pkg::CNT_W-1:0] cnt_nxt;
  logic [cdpt_pkg::CNT_W-1:0] pon_r;
  logic [cdpt_pkg::CNT_W-1:0] poff_r;
  logic [cdpt_pkg::CNT_W-1:0] pon_nxt;
  logic [cdpt_pkg::CNT_W-1:0] poff_nxt;
  logic out_on_r;
  logic off_phase_r;

  assign rise = ch.en & ~en_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= ch.en;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pon_nxt = pon_r;
    poff_nxt = poff_r;
    if (!ch.en) begin
      state_nxt = cdpt_pkg::CDPT_ST_IDLE;
    end else if (rise) begin
      pon_nxt = ch.pulse_on_cnt;
      poff_nxt = ch.pulse_off_cnt;
      cnt_nxt = ch.delay_cnt;
      state_nxt = cdpt_pkg::CDPT_ST_DELAY;
      if (ch.delay_cnt == cdpt_pkg::RST_COUNT) begin
        if (ch.pulse_on_cnt == cdpt_pkg::RST_COUNT ||
            ch.pulse_off_cnt == cdpt_pkg::RST_COUNT) begin
          state_nxt = cdpt_pkg::CDPT_ST_STEADY;
        end else begin
          state_nxt = cdpt_pkg::CDPT_ST_PON;
          cnt_nxt = ch.pulse_on_cnt;
        end
      end
    end else begin
      unique case (state_r)
        cdpt_pkg::CDPT_ST_DELAY: begin
          if (ch.tick_delay) begin
            cnt_nxt = cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
              if (pon_r == cdpt_pkg::RST_COUNT ||
                  poff_r == cdpt_pkg::RST_COUNT) begin
                state_nxt = cdpt_pkg::CDPT_ST_STEADY;
              end else begin
                state_nxt = cdpt_pkg::CDPT_ST_PON;
                cnt_nxt = pon_r;
              end
            end
          end
        end
        cdpt_pkg::CDPT_ST_PON: begin
          if (ch.tick_pulse) begin
            cnt_nxt = cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
              state_nxt = cdpt_pkg::CDPT_ST_POFF;
              cnt_nxt = poff_r;
            end
          end
        end
        cdpt_pkg::CDPT_ST_POFF: begin
          if (ch.tick_pulse) begin
            cnt_nxt = cnt_r - 10'h001;
            if (cnt_r == 10'h001) begin
              state_nxt = cdpt_pkg::CDPT_ST_PON;
              cnt_nxt = pon_r;
            end
          end
        end
        cdpt_pkg::CDPT_ST_IDLE, cdpt_pkg::CDPT_ST_STEADY: begin
          state_nxt = state_r;
        end
        default: begin
          state_nxt = cdpt_pkg::CDPT_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cdpt_pkg::CDPT_ST_IDLE;
      cnt_r <= cdpt_pkg::RST_COUNT;
      pon_r <= cdpt_pkg::RST_COUNT;
      poff_r <= cdpt_pkg::RST_COUNT;
      out_on_r <= 1'b0;
      off_phase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pon_r <= pon_nxt;
      poff_r <= poff_nxt;
      out_on_r <= (state_nxt == cdpt_pkg::CDPT_ST_PON) ||
                  (state_nxt == cdpt_pkg::CDPT_ST_STEADY);
      off_phase_r <= (state_nxt == cdpt_pkg::CDPT_ST_POFF);
    end
  end

  assign ch.out_on = out_on_r;
  assign ch.off_phase = off_phase_r;

endmodule : cdpt_ch_timer
`default_nettype wire

// ==== hdl/cdpt_top.sv ====
// Three-channel turn-on delay and pulse timer with APB registers
`timescale 1ns/10ps
`default_nettype none
module cdpt_top #(
  parameter int unsigned CH = cdpt_pkg::CH_NUM
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cdpt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel pins
  input wire logic [CH-1:0] channel_enable_input,
  input wire logic ext_clk_in,
  output logic [CH-1:0] channel_current_output,
  // Converter feedback
  output logic feedback_drive
);

  logic [1:0] mode_r;
  logic fbdis_r;
  logic [1:0] clk_src_r;
  logic [cdpt_pkg::DIV_W-1:0] div_dly_r;
  logic [cdpt_pkg::DIV_W-1:0] div_pls_r;
  logic [cdpt_pkg::CNT_W-1:0] delay_r [CH];
  logic [cdpt_pkg::CNT_W-1:0] pon_r [CH];
  logic [cdpt_pkg::CNT_W-1:0] poff_r [CH];

  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;
  logic pready_r;
  logic pslverr_r;
  logic hit;
  logic wr_en;

  logic [$clog2(cdpt_pkg::INT_TICK_CYC+1)-1:0] int_cnt_r;
  logic int_tick;
  logic ext_prev_r;
  logic ext_tick;
  logic base_tick;
  logic [6:0] dly_cnt_r;
  logic [6:0] pls_cnt_r;
  logic [6:0] dly_mask;
  logic [6:0] pls_mask;
  logic tick_dly;
  logic tick_pls;

  logic [CH-1:0] out_on;
  logic [CH-1:0] off_phase;
  logic [CH-1:0] out_r;
  logic fb_r;
  logic div_low;

  // APB access phase with the one-cycle ready
  assign wr_en = psel & penable & pwrite & pready_r;

  function automatic logic [6:0] div_mask(input logic [3:0] f);
    logic [3:0] n;
    n = (f > cdpt_pkg::DIV_MAX_LOG2) ? cdpt_pkg::DIV_MAX_LOG2 : f;
    div_mask = 7'((8'h01 << n) - 8'h01);
  endfunction : div_mask

  function automatic logic [11:0] ch_addr(input int unsigned i,
                                          input logic [11:0] ofs);
    ch_addr = 12'(cdpt_pkg::ADDR_CH_BASE + i * cdpt_pkg::ADDR_CH_STRIDE
                  + ofs);
  endfunction : ch_addr

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= cdpt_pkg::RST_MODE;
    end else if (wr_en && paddr == cdpt_pkg::ADDR_OPCTL) begin
      mode_r <= pwdata[cdpt_pkg::OPCTL_MODE_LSB +: 2];
    end
  end

  // Feedback disconnect bit shares the mode word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fbdis_r <= cdpt_pkg::RST_FBDIS;
    end else if (wr_en && paddr == cdpt_pkg::ADDR_OPCTL) begin
      fbdis_r <= pwdata[cdpt_pkg::OPCTL_FBDIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src_r <= cdpt_pkg::RST_CLK_SRC;
    end else if (wr_en && paddr == cdpt_pkg::ADDR_CLKCTL) begin
      clk_src_r <= pwdata[cdpt_pkg::CLK_SRC_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_dly_r <= cdpt_pkg::RST_DIV;
    end else if (wr_en && paddr == cdpt_pkg::ADDR_DIVCTL) begin
      div_dly_r <= pwdata[cdpt_pkg::DIV_DLY_LSB +: cdpt_pkg::DIV_W];
    end
  end

  // Pulse divider ratio, set apart from the delay one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_pls_r <= cdpt_pkg::RST_DIV;
    end else if (wr_en && paddr == cdpt_pkg::ADDR_DIVCTL) begin
      div_pls_r <= pwdata[cdpt_pkg::DIV_PLS_LSB +: cdpt_pkg::DIV_W];
    end
  end

  // Read data and decode
  always_comb begin
    rd_nxt = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr)
      cdpt_pkg::ADDR_OPCTL: begin
        rd_nxt[cdpt_pkg::OPCTL_MODE_LSB +: 2] = mode_r;
        rd_nxt[cdpt_pkg::OPCTL_FBDIS_BIT] = fbdis_r;
      end
      cdpt_pkg::ADDR_CLKCTL: begin
        rd_nxt[cdpt_pkg::CLK_SRC_LSB +: 2] = clk_src_r;
      end
      cdpt_pkg::ADDR_DIVCTL: begin
        rd_nxt[cdpt_pkg::DIV_DLY_LSB +: cdpt_pkg::DIV_W] = div_dly_r;
        rd_nxt[cdpt_pkg::DIV_PLS_LSB +: cdpt_pkg::DIV_W] = div_pls_r;
      end
      cdpt_pkg::ADDR_STATUS: begin
        // Enable bits show the raw pins
        rd_nxt[cdpt_pkg::ST_OUT_LSB +: CH] = out_r;
        rd_nxt[cdpt_pkg::ST_EN_LSB +: CH] = channel_enable_input;
        rd_nxt[cdpt_pkg::ST_OFF_LSB +: CH] = off_phase;
        rd_nxt[cdpt_pkg::ST_DIVLOW_BIT] = div_low;
        rd_nxt[cdpt_pkg::ST_EXT_BIT] = (clk_src_r == cdpt_pkg::CLK_SRC_EXT);
      end
      default: begin
        hit = 1'b0;
        for (int unsigned i = 0; i < CH; i++) begin
          if (paddr == ch_addr(i, cdpt_pkg::CH_DELAY_OFS)) begin
            rd_nxt[cdpt_pkg::CNT_W-1:0] = delay_r[i];
            hit = 1'b1;
          end
          if (paddr == ch_addr(i, cdpt_pkg::CH_PON_OFS)) begin
            rd_nxt[cdpt_pkg::CNT_W-1:0] = pon_r[i];
            hit = 1'b1;
          end
          if (paddr == ch_addr(i, cdpt_pkg::CH_POFF_OFS)) begin
            rd_nxt[cdpt_pkg::CNT_W-1:0] = poff_r[i];
            hit = 1'b1;
          end
        end
      end
    endcase
  end

  // Answer in the first access cycle, no waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel & ~penable;
    end
  end

  // Error rides with ready for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel & ~penable & ~hit;
    end
  end

  // Read word held until the next read setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_nxt;
    end
  end

  // Internal tick: pclk divided to the 40 ns timer period
  assign int_tick = (int_cnt_r == ($bits(int_cnt_r))'(
                     cdpt_pkg::INT_TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_r <= '0;
    end else if (int_tick) begin
      int_cnt_r <= '0;
    end else begin
      int_cnt_r <= int_cnt_r + 1'b1;
    end
  end

  // External edges, up to half of pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_clk_in;
    end
  end

  assign ext_tick = ext_clk_in & ~ext_prev_r;

  assign base_tick = (clk_src_r == cdpt_pkg::CLK_SRC_EXT) ? ext_tick
                                                           : int_tick;

  assign dly_mask = div_mask(div_dly_r);
  assign pls_mask = div_mask(div_pls_r);
  assign tick_dly = base_tick && ((dly_cnt_r & dly_mask) == dly_mask);
  assign tick_pls = base_tick && ((pls_cnt_r & pls_mask) == pls_mask);

  // Free-running: first divided tick may land anywhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_r <= 7'h00;
    end else if (base_tick) begin
      dly_cnt_r <= dly_cnt_r + 7'h01;
    end
  end

  // Pulse divider counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pls_cnt_r <= 7'h00;
    end else if (base_tick) begin
      pls_cnt_r <= pls_cnt_r + 7'h01;
    end
  end

  // Flag a pulse divider below 8 when the mode is not open
  assign div_low = (mode_r != cdpt_pkg::CDPT_MODE_OPEN) &&
                   (div_pls_r < cdpt_pkg::MPG_MIN_DIV_LOG2);

  // Per-channel count registers and timers
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      cdpt_ch_if chl ();

      // Counts reach the timer only at an enable rise
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          delay_r[g] <= cdpt_pkg::RST_COUNT;
        end else if (wr_en &&
                     paddr == ch_addr(g, cdpt_pkg::CH_DELAY_OFS)) begin
          delay_r[g] <= pwdata[cdpt_pkg::CNT_W-1:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pon_r[g] <= cdpt_pkg::RST_COUNT;
        end else if (wr_en &&
                     paddr == ch_addr(g, cdpt_pkg::CH_PON_OFS)) begin
          pon_r[g] <= pwdata[cdpt_pkg::CNT_W-1:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          poff_r[g] <= cdpt_pkg::RST_COUNT;
        end else if (wr_en &&
                     paddr == ch_addr(g, cdpt_pkg::CH_POFF_OFS)) begin
          poff_r[g] <= pwdata[cdpt_pkg::CNT_W-1:0];
        end
      end

      // Mode does not reach the timer
      assign chl.en = channel_enable_input[g];
      assign chl.tick_delay = tick_dly;
      assign chl.tick_pulse = tick_pls;
      assign chl.delay_cnt = delay_r[g];
      assign chl.pulse_on_cnt = pon_r[g];
      assign chl.pulse_off_cnt = poff_r[g];
      assign out_on[g] = chl.out_on;
      assign off_phase[g] = chl.off_phase;

      cdpt_ch_timer u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .ch(chl.tmr)
      );
    end
  endgenerate

  // Outputs registered once more; fall still clears at once below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
    end else begin
      out_r <= out_on & channel_enable_input;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_r <= 1'b1;
    end else begin
      fb_r <= ~(fbdis_r & (|off_phase));
    end
  end

  assign channel_current_output = out_r;
  assign feedback_drive = fb_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : cdpt_top
`default_nettype wire

// ==== verif/cdpt_top_monitor.sv ====
// Port-level checks for the channel delay and pulse timer
`timescale 1ns/10ps
`default_nettype none
module cdpt_top_monitor #(
  parameter int unsigned CH = 3
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cdpt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel pins
  input wire logic [CH-1:0] channel_enable_input,
  input wire logic ext_clk_in,
  input wire logic [CH-1:0] channel_current_output,
  // Converter feedback
  input wire logic feedback_drive
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [CH-1:0] en;
  logic [CH-1:0] out;
  assign en = channel_enable_input;
  assign out = channel_current_output;

  a_fall_off: assert property ((~$past(en) & out) == '0)
    else $error("output on after enable low");
  a_rise_late: assert property (
    ((out & ~$past(out)) & ~($past(en) & $past(en, 2))) == '0)
    else $error("output rose too early");
  a_reset_clean: assert property (
    $rose(presetn) |-> out == '0 && feedback_drive && !pready)
    else $error("outputs not idle after reset");
  a_fb_cause: assert property (
    !feedback_drive |-> |($past(en) | $past(en, 2) | $past(en, 3)))
    else $error("feedback released with no channel enabled");
  a_ready_setup: assert property ((psel && !penable) |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_ready_one: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_hold: assert property (
    !$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("read data changed without read");

  cover property ($rose(out[0]));
  cover property (pslverr);
  cover property (!feedback_drive);
endmodule : cdpt_top_monitor
`default_nettype wire

// ==== verif/cdpt_disp_model.sv ====
// Display controller model: channel enables and external timer clock
`timescale 1ns/10ps
`default_nettype none
module cdpt_disp_model #(
  parameter int EXT_Q = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic [2:0] want,
  input wire logic ext_run,
  // Pins toward the block
  output logic [2:0] en,
  output logic ext_clk
);
  int q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      en <= 3'h0;
    else
      en <= want;
  end
  // External clock no faster than half pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 0;
      ext_clk <= 1'b0;
    end else if (ext_run) begin
      q <= (q == EXT_Q / 2 - 1) ? 0 : q + 1;
      if (q == EXT_Q / 2 - 1)
        ext_clk <= ~ext_clk;
    end
  end
endmodule : cdpt_disp_model
`default_nettype wire

// ==== verif/cdpt_top_tb.sv ====
// Self-checking bench for the channel delay and pulse timer
`timescale 1ns/10ps
`default_nettype none
module cdpt_top_tb;
  localparam int EXT_Q = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] want = 3'h0;
  logic ext_run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] en_w;
  logic ext_w;
  logic [2:0] out_w;
  logic fb;
  int mismatches = 0;
  int comparisons = 0;
  logic [15:0] seed = 16'he495;
  logic [31:0] rd;
  logic er;
  logic [3:0] d;
  int lat, i, k, ch, nn, n, lows;
  int cn[3] = '{1023, 1, 2};
  logic [3:0] cd[3] = '{4'h0, 4'h7, 4'h9};

  always #10 pclk = ~pclk;

  cdpt_top #(.CH(3)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_enable_input(en_w),
    .ext_clk_in(ext_w), .channel_current_output(out_w),
    .feedback_drive(fb));
  cdpt_disp_model #(.EXT_Q(EXT_Q)) host (
    .pclk(pclk), .presetn(presetn), .want(want), .ext_run(ext_run),
    .en(en_w), .ext_clk(ext_w));

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  // Timer clocks per divided tick
  function int per(input logic [3:0] dv, input bit x);
    return (x ? EXT_Q : 2) << ((dv > 4'h7) ? 4'h7 : dv);
  endfunction : per

  function logic [11:0] cha(input int c, input logic [11:0] o);
    return cdpt_pkg::ADDR_CH_BASE + cdpt_pkg::ADDR_CH_STRIDE * 12'(c) + o;
  endfunction : cha

  task step;
    @(posedge pclk);
    #1;
  endtask : step

  task apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc

  task setch(input int c, input logic [9:0] dl, pn, pf);
    wr(cha(c, cdpt_pkg::CH_DELAY_OFS), {22'h0, dl});
    wr(cha(c, cdpt_pkg::CH_PON_OFS), {22'h0, pn});
    wr(cha(c, cdpt_pkg::CH_POFF_OFS), {22'h0, pf});
  endtask : setch

  task run_on(input int c);
    #1;
    want[c] = 1'b1;
    @(posedge pclk);
    for (lat = 0; lat == 0 || (out_w[c] !== 1'b1 && lat < 5000); lat++)
      step();
  endtask : run_on

  task en_off(input int c);
    #1;
    want[c] = 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    check(32'(out_w[c]), 32'h0);
  endtask : en_off

  task dly(input int c, input int dn, input int p);
    run_on(c);
    if (dn == 0)
      check(lat, 2);
    else
      check(32'(lat >= 2 + (dn - 1) * p && lat <= 3 + dn * p), 32'h1);
  endtask : dly

  task hold(input int c, input int cyc);
    lows = 0;
    repeat (cyc) begin
      step();
      if (out_w[c] !== 1'b1)
        lows++;
    end
  endtask : hold

  task runs(input int c, input int p, input int pn, input int pf,
      input logic efb);
    int m;
    logic f;
    f = 1'b1;
    run_on(c);
    for (m = 0; out_w[c] === 1'b1 && m < 9000; m++)
      step();
    for (m = 0; out_w[c] !== 1'b1 && m < 9000; m++) begin
      if (m == 2)
        f = fb;
      step();
    end
    check(m, pf * p);
    check(f, efb);
    for (m = 0; out_w[c] === 1'b1 && m < 9000; m++)
      step();
    check(m, pn * p);
    en_off(c);
  endtask : runs

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    step();
    check(32'({out_w, fb}), 32'h1);
    rdc(cdpt_pkg::ADDR_OPCTL, 32'h0);
    rdc(cdpt_pkg::ADDR_CLKCTL, 32'h0);
    rdc(cdpt_pkg::ADDR_DIVCTL, 32'h0);
    rdc(cdpt_pkg::ADDR_STATUS, 32'h0);
    for (ch = 0; ch < 3; ch++)
      for (k = 0; k < 3; k++)
        rdc(cha(ch, 12'(4 * k)), 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    check({rd[30:0], er}, 32'h1);
    $display("test reset done");
    dly(0, 0, 2);
    hold(0, 30);
    check(lows, 0);
    en_off(0);
    for (i = 0; i < 9; i++) begin
      ch = i % 3;
      d = (i < 3) ? cd[i] : 4'(rnd() & 16'h3);
      nn = (i < 3) ? cn[i] : int'(rnd() % 16'h14) + 1;
      wr(cdpt_pkg::ADDR_OPCTL, 32'(i % 3));
      wr(cdpt_pkg::ADDR_DIVCTL, {20'h0, 4'h3, 4'h0, d});
      setch(ch, 10'(nn), 10'h0, 10'h0);
      dly(ch, nn, per(d, 1'b0));
      en_off(ch);
    end
    $display("test delay done");
    wr(cdpt_pkg::ADDR_OPCTL, 32'h0);
    setch(1, 10'h004, 10'h0, 10'h0);
    dly(1, 4, per(d, 1'b0));
    setch(1, 10'h01e, 10'h001, 10'h001);
    hold(1, 10);
    check(lows, 0);
    en_off(1);
    dly(1, 30, per(d, 1'b0));
    en_off(1);
    $display("test capture done");
    wr(cdpt_pkg::ADDR_DIVCTL, 32'h0);
    setch(2, 10'h0, 10'h003, 10'h002);
    runs(2, 2, 3, 2, 1'b1);
    wr(cdpt_pkg::ADDR_OPCTL, 32'h21);
    wr(cdpt_pkg::ADDR_DIVCTL, 32'h300);
    setch(2, 10'h0, 10'h001, 10'h001);
    runs(2, 16, 1, 1, 1'b0);
    setch(2, 10'h0, 10'h005, 10'h0);
    run_on(2);
    hold(2, 40);
    check(lows, 0);
    en_off(2);
    $display("test pulse done");
    wr(cdpt_pkg::ADDR_DIVCTL, 32'h0);
    rdc(cdpt_pkg::ADDR_STATUS, 32'h100);
    wr(cdpt_pkg::ADDR_OPCTL, 32'h0);
    wr(cdpt_pkg::ADDR_CLKCTL, 32'h2);
    rdc(cdpt_pkg::ADDR_STATUS, 32'h200);
    setch(0, 10'h003, 10'h0, 10'h0);
    #1;
    want[0] = 1'b1;
    hold(0, 100);
    check(lows, 100);
    ext_run = 1'b1;
    for (n = 0; out_w[0] !== 1'b1 && n < 100; n++)
      step();
    check(32'(n <= 3 * EXT_Q + 8), 32'h1);
    en_off(0);
    setch(0, 10'h0, 10'h001, 10'h001);
    runs(0, EXT_Q, 1, 1, 1'b1);
    ext_run = 1'b0;
    wr(cdpt_pkg::ADDR_CLKCTL, 32'h0);
    $display("test external done");
    run_on(0);
    presetn = 1'b0;
    want = 3'h0;
    #1;
    check(32'({out_w, fb}), 32'h1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(cha(0, cdpt_pkg::CH_PON_OFS), 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule : cdpt_top_tb

bind cdpt_top cdpt_top_monitor #(.CH(CH)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .channel_enable_input(channel_enable_input), .ext_clk_in(ext_clk_in),
  .channel_current_output(channel_current_output),
  .feedback_drive(feedback_drive));
`default_nettype wire
